// File: bench/mfr_front_end_bench.sv
// Self-checking bench for the multi-line fast read front end.
`timescale 1ns/100ps
module mfr_front_end_bench;
  typedef struct {logic [7:0] c; int al, ml, dm, dl; logic [7:0] m; logic [23:0] a;} mfr_row_t;
  logic        CLOCK = 0, NRST = 0, ack = 0, qe = 1, qcm = 0, wld = 0, pld = 0, rsi = 0;
  logic        tog = 0, oe_seen = 0, sclk, cs_n, hen, req, cont;
  logic [3:0]  io_out, io_oe, hdrv, io_in;
  logic [2:0]  wset = 0, wbits;
  logic [1:0]  pin = 0, rp;
  logic [23:0] maddr;
  int          mismatches = 0, n_compared = 0;
  mfr_row_t    rows [4] = '{'{8'h3b, 1, 0, 8, 2, 8'h00, 24'h000010},
                            '{8'h6b, 1, 0, 8, 4, 8'h00, 24'h0000f0},
                            '{8'hbb, 2, 2, 0, 2, 8'h00, 24'h123456},
                            '{8'heb, 4, 4, 4, 4, 8'h0f, 24'h0001fe}};
  // Released lines show a moving pattern so stale values never pass.
  assign io_in = hen ? hdrv : (io_oe & io_out) | (~io_oe & {4{tog}});
  initial forever #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) tog <= ~tog;
  always @(posedge CLOCK) oe_seen <= oe_seen | (|io_oe);
  always @(negedge CLOCK) ack <= req & ~ack;
  mfr_front_end u_mfr_front_end (.CLOCK(CLOCK), .NRST(NRST), .SCLK(sclk), .CS_N(cs_n),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_LINES_ENABLE_BIT(qe),
    .QUAD_COMMAND_MODE(qcm), .WRAP_LOAD(wld), .WRAP_SETTING_IN(wset), .PARAM_LOAD(pld),
    .PARAM_IN(pin), .RESET_INSTR(rsi), .MEM_REQ(req), .MEM_ADDR(maddr), .MEM_ACK(ack),
    .MEM_DATA(maddr[7:0] ^ 8'ha5), .CONT_MODE(cont), .WRAP_SETTING_BITS(wbits),
    .READ_PARAM(rp));
  mfr_host_model u_mfr_host_model (.clk(CLOCK), .io_out(io_out), .sclk(sclk), .cs_n(cs_n),
    .drv(hdrv), .drv_en(hen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input mfr_row_t r, input int cl, nb, input logic [23:0] msk);
    logic [23:0] ex;
    u_mfr_host_model.frame(r.c, cl, r.al, r.ml, r.dm, r.dl, r.a, r.m, nb);
    for (int i = 0; i < nb; i++) begin
      ex = (r.a & ~msk) | ((r.a + 24'(i)) & msk);
      check("data", u_mfr_host_model.got[i], ex[7:0] ^ 8'ha5);
    end
    $display("test %h done", r.c);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (20) @(negedge CLOCK);
    NRST = 1;
    repeat (4) @(negedge CLOCK);
    check("cont", cont, 0);
    check("wrap", wbits, 8'h01);
    check("param", rp, 0);
    foreach (rows[k]) run(rows[k], 1, 3, 24'hffffff);
    run('{8'heb, 4, 4, 4, 4, 8'h20, 24'h000300}, 1, 2, 24'hffffff);
    check("cont", cont, 1);
    run('{8'heb, 4, 4, 4, 4, 8'h11, 24'h111111}, 0, 2, 24'hffffff);
    check("cont", cont, 0);
    run('{8'hbb, 2, 2, 0, 2, 8'h20, 24'h000100}, 1, 1, 24'hffffff);
    check("cont", cont, 1);
    run('{8'hbb, 2, 2, 0, 2, 8'h55, 24'h555555}, 0, 1, 24'hffffff);
    check("cont", cont, 0);
    qe = 0;
    oe_seen = 0;
    u_mfr_host_model.frame(8'h6b, 1, 1, 0, 8, 4, 24'h0, 8'h0, 1);
    u_mfr_host_model.frame(8'heb, 1, 4, 4, 4, 4, 24'h0, 8'h0, 1);
    check("oe", oe_seen, 0);
    $display("test gate done");
    qe = 1;
    wld = 1;
    @(negedge CLOCK) wld = 0;
    check("wrap", wbits, 0);
    run('{8'heb, 4, 4, 4, 4, 8'h00, 24'h000006}, 1, 4, 24'h000007);
    qcm = 1;
    pin = 2'h1;
    pld = 1;
    @(negedge CLOCK) pld = 0;
    run('{8'heb, 4, 4, 2, 4, 8'h00, 24'h000007}, 4, 2, 24'hffffff);
    rsi = 1;
    @(negedge CLOCK) rsi = 0;
    check("param", rp, 0);
    run('{8'heb, 4, 4, 0, 4, 8'h20, 24'h000020}, 4, 2, 24'hffffff);
    check("cont", cont, 1);
    NRST = 0;
    repeat (4) @(negedge CLOCK);
    NRST = 1;
    @(negedge CLOCK);
    check("cont", cont, 0);
    check("wrap", wbits, 8'h01);
    $display("test reset done");
    wrap_up;
  end
endmodule // mfr_front_end_bench

// File: bench/mfr_host_model.sv
// Host controller model that drives the serial lines.
`timescale 1ns/100ps
module mfr_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      drv,
  output logic            drv_en
);
  logic [7:0] got [0:7];
  initial begin
    sclk = 0;
    cs_n = 1;
    drv = 0;
    drv_en = 0;
  end
  // The serial clock only runs inside frames.
  task automatic tick(input logic [3:0] d, input logic en);
    @(negedge clk) sclk = 0;
    drv = d;
    drv_en = en;
    repeat (4) @(negedge clk);
    sclk = 1;
    repeat (4) @(negedge clk);
  endtask
  task automatic send(input logic [23:0] v, input int ln, input int n);
    for (int k = n - 1; k >= 0; k--) tick(4'(v >> (k * ln)) & 4'((1 << ln) - 1), 1'b1);
  endtask
  task automatic frame(input logic [7:0] c, input int cl, al, ml, dm, dl,
                       input logic [23:0] a, input logic [7:0] m, input int nb);
    logic [7:0] b;
    @(negedge clk) cs_n = 0;
    repeat (4) @(negedge clk);
    if (cl > 0) send(24'(c), cl, 8 / cl);
    send(a, al, 24 / al);
    if (ml > 0) send(24'(m), ml, 8 / ml);
    repeat (dm) tick(4'h0, 1'b0);
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < 8 / dl; j++) begin
        tick(4'h0, 1'b0);
        b = (b << dl) | 8'(io_out & 4'((1 << dl) - 1));
      end
      got[i] = b;
    end
    repeat (4) @(negedge clk) sclk = 0;
    repeat (4) @(negedge clk) cs_n = 1;
    repeat (8) @(negedge clk);
  endtask
endmodule // mfr_host_model

// File: logic/mfr_fifo.sv
// Prefetch buffer between the memory read port and the serial shifter.
`timescale 1ns/100ps
module mfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } mfr_fifo_st_t;

  mfr_fifo_st_t q;
  mfr_fifo_st_t d;

  ////////////////////////////////////////////////////////////////////////////////
  // The extra pointer bit tells a full buffer from an empty one.
  assign in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign out_valid = (q.wp != q.rp);
  assign out_data  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (flush) begin
      d.wp = '0;
      d.rp = '0;
    end else begin
      if (in_valid && in_ready) begin
        d.mem[q.wp[AW-1:0]] = in_data;
        d.wp = q.wp + {{AW{1'b0}}, 1'b1};
      end
      if (out_valid && out_ready) begin
        d.rp = q.rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // mfr_fifo

// File: logic/mfr_front_end.sv
// Serial flash front end for dual and quad fast read instructions.
// Overview of operation
// - Dual output read returns data on two lines.
// - Eight ignored dummy clocks follow address on output reads.
// - Quad output read returns data on four lines.
// - Quad output read needs quad lines enable bit.
// - Continuous-mode byte follows address; low nibble ignored.
// - Select bits one-zero skip next instruction code.
// - Any other select value restores full instruction.
// - Quad IO read uses four lines, four dummies.
// - Quad IO read needs quad lines enable bit.
// - Enabled wrap restarts at aligned section start.
// - Three wrap bits held: disable and length.
// - Quad command mode dummies are 2,4,6,8.
// - Dummy count resets to two.
// - Mode byte clocks count toward dummy total.
// - Continuous mode also works in quad command mode.
// - Quad command mode ignores the wrap setting.
// - Wrap resets disabled; lengths 8 to 64.
// - Only three bits of wrap byte used.
// - Address advances by one after each byte.
// - Capture on rising edge, launch MSB on falling.
`timescale 1ns/100ps
module mfr_front_end #(
  parameter int FIFO_DEPTH = mfr_pkg::FIFO_DEPTH
) (
  input  wire logic                      CLOCK,
  input  wire logic                      NRST,
  input  wire logic                      SCLK,
  input  wire logic                      CS_N,
  input  wire logic [3:0]                IO_IN,
  output logic [3:0]                     IO_OUT,
  output logic [3:0]                     IO_OE,
  input  wire logic                      QUAD_LINES_ENABLE_BIT,
  input  wire logic                      QUAD_COMMAND_MODE,
  input  wire logic                      WRAP_LOAD,
  input  wire logic [2:0]                WRAP_SETTING_IN,
  input  wire logic                      PARAM_LOAD,
  input  wire logic [1:0]                PARAM_IN,
  input  wire logic                      RESET_INSTR,
  output logic                           MEM_REQ,
  output logic [mfr_pkg::ADDR_W-1:0]     MEM_ADDR,
  input  wire logic                      MEM_ACK,
  input  wire logic [7:0]                MEM_DATA,
  output logic                           CONT_MODE,
  output logic [2:0]                     WRAP_SETTING_BITS,
  output logic [1:0]                     READ_PARAM
);

  typedef struct packed {
    logic [2:0]                 sclk_sync;
    logic [2:0]                 csn_sync;
    logic [2:0][3:0]            io_sync;
    logic                       sclk_lvl;
    logic                       csn_lvl;
    logic [3:0]                 io_lvl;
    mfr_pkg::mfr_phase_t        phase;
    mfr_pkg::mfr_kind_t         kind;
    logic [2:0]                 width;
    logic [4:0]                 cnt;
    logic [23:0]                sh;
    logic [3:0]                 dummy;
    logic                       cont;
    mfr_pkg::mfr_kind_t         cont_kind;
    logic [2:0]                 wrap;
    logic [1:0]                 rdparam;
    logic                       wrap_act;
    logic [7:0]                 dout;
    logic [3:0]                 dleft;
    logic [3:0]                 io_out;
    logic [3:0]                 io_oe;
    logic [mfr_pkg::ADDR_W-1:0] faddr;
    logic                       fetch_on;
    logic                       req;
    logic                       stale;
    logic                       flush;
  } mfr_state_t;

  mfr_state_t q;
  mfr_state_t d;

  logic       sclk_n;
  logic       csn_n;
  logic [3:0] io_n;
  logic       rise;
  logic       fall;
  logic       cs_start;
  logic       cs_end;
  logic [4:0] cnt_next;
  logic [23:0] sh_n;
  logic [2:0] dw;
  logic [7:0] wmask;
  logic       cmd_done;
  logic       addr_done;
  logic       mode_done;
  logic       accept;
  logic       pop;
  logic [7:0] out_byte;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////////
  // A synchronised level only moves once the second and third stages agree.
  function automatic logic filt(input logic prev, input logic s2, input logic s3);
    return (s2 == s3) ? s3 : prev;
  endfunction

  // Lane count on the wire for each instruction's data phase.
  function automatic logic [2:0] data_width(input mfr_pkg::mfr_kind_t k);
    case (k)
      mfr_pkg::K_QUAD_OUT,
      mfr_pkg::K_QUAD_IO:  data_width = mfr_pkg::LANE_4;
      default:             data_width = mfr_pkg::LANE_2;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] io,
                                           input logic [2:0] w);
    case (w)
      mfr_pkg::LANE_2: shift_in = {s[21:0], io[1:0]};
      mfr_pkg::LANE_4: shift_in = {s[19:0], io};
      default:         shift_in = {s[22:0], io[0]};
    endcase
  endfunction

  function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] w);
    case (w)
      mfr_pkg::LANE_4: top_bits = b[7:4];
      default:         top_bits = {2'h0, b[7:6]};
    endcase
  endfunction

  function automatic logic [7:0] shl(input logic [7:0] b, input logic [2:0] w);
    case (w)
      mfr_pkg::LANE_4: shl = {b[3:0], 4'h0};
      default:         shl = {b[5:0], 2'h0};
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] w);
    case (w)
      mfr_pkg::LANE_4: lane_mask = 4'hf;
      default:         lane_mask = 4'h3;
    endcase
  endfunction

  function automatic logic [7:0] wrap_mask(input logic [1:0] len);
    case (len)
      2'h0:    wrap_mask = mfr_pkg::WRAP_MASK_8;
      2'h1:    wrap_mask = mfr_pkg::WRAP_MASK_16;
      2'h2:    wrap_mask = mfr_pkg::WRAP_MASK_32;
      default: wrap_mask = mfr_pkg::WRAP_MASK_64;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Edge and phase detection on the filtered link signals.
  assign sclk_n = filt(q.sclk_lvl, q.sclk_sync[1], q.sclk_sync[2]);
  assign csn_n  = filt(q.csn_lvl, q.csn_sync[1], q.csn_sync[2]);
  for (genvar i = 0; i < 4; i++) begin : g_io_filt
    assign io_n[i] = filt(q.io_lvl[i], q.io_sync[1][i], q.io_sync[2][i]);
  end

  assign rise      = !q.sclk_lvl && sclk_n && !csn_n;
  assign fall      = q.sclk_lvl && !sclk_n && !csn_n;
  assign cs_start  = q.csn_lvl && !csn_n;
  assign cs_end    = !q.csn_lvl && csn_n;
  assign cnt_next  = q.cnt + {2'h0, q.width};
  assign sh_n      = shift_in(q.sh, io_n, q.width);
  assign dw        = data_width(q.kind);
  assign wmask     = wrap_mask(q.wrap[mfr_pkg::WRAP_LEN_HI:mfr_pkg::WRAP_LEN_LO]);
  assign cmd_done  = rise && (q.phase == mfr_pkg::PH_CMD) && (cnt_next == mfr_pkg::CMD_BITS);
  assign addr_done = rise && (q.phase == mfr_pkg::PH_ADDR) && (cnt_next == mfr_pkg::ADDR_BITS);
  assign mode_done = rise && (q.phase == mfr_pkg::PH_MODE) && (cnt_next == mfr_pkg::MODE_BITS);
  assign accept    = q.req && MEM_ACK && !q.stale;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    pop = 1'b0;
    out_byte = mfr_pkg::FILL_BYTE;
    d.sclk_sync = {q.sclk_sync[1:0], SCLK};
    d.csn_sync  = {q.csn_sync[1:0], CS_N};
    d.io_sync   = {q.io_sync[1:0], IO_IN};
    d.sclk_lvl  = sclk_n;
    d.csn_lvl   = csn_n;
    d.io_lvl    = io_n;
    d.flush     = cs_start || cs_end;
    if (WRAP_LOAD) begin
      d.wrap = WRAP_SETTING_IN;
    end
    if (RESET_INSTR) begin
      d.rdparam = mfr_pkg::PARAM_RESET;
      d.cont    = 1'b0;
    end
    if (PARAM_LOAD) begin
      d.rdparam = PARAM_IN;
    end
    // Prefetch runs ahead of the shifter until the buffer is full; one request is in flight at most.
    if (q.req && MEM_ACK) begin
      d.req   = 1'b0;
      d.stale = 1'b0;
      if (!q.stale) begin
        if (q.wrap_act) begin
          d.faddr[7:0] = (q.faddr[7:0] & ~wmask) | ((q.faddr[7:0] + 8'h01) & wmask);
        end else begin
          d.faddr = q.faddr + 24'h000001;
        end
      end
    // A request raised as the frame closes would come back unmarked as stale.
    end else if (!q.req && q.fetch_on && fifo_in_ready && !q.flush && !cs_end) begin
      d.req = 1'b1;
    end
    if (cs_end) begin
      d.phase    = mfr_pkg::PH_IDLE;
      d.io_oe    = 4'h0;
      d.io_out   = 4'h0;
      d.fetch_on = 1'b0;
      d.stale    = q.req && !MEM_ACK;
    end else if (cs_start) begin
      d.cnt   = 5'h00;
      d.dleft = 4'h0;
      if (q.cont) begin
        d.phase = mfr_pkg::PH_ADDR;
        d.kind  = q.cont_kind;
        d.width = (q.cont_kind == mfr_pkg::K_QUAD_IO) ? mfr_pkg::LANE_4 : mfr_pkg::LANE_2;
      end else begin
        d.phase = mfr_pkg::PH_CMD;
        d.kind  = mfr_pkg::K_NONE;
        d.width = QUAD_COMMAND_MODE ? mfr_pkg::LANE_4 : mfr_pkg::LANE_1;
      end
    end else begin
      case (q.phase)
        mfr_pkg::PH_CMD: begin
          if (rise) begin
            d.sh  = sh_n;
            d.cnt = cnt_next;
          end
          if (cmd_done) begin
            d.cnt   = 5'h00;
            d.phase = mfr_pkg::PH_ADDR;
            d.width = mfr_pkg::LANE_1;
            if (QUAD_COMMAND_MODE) begin
              if (sh_n[7:0] == mfr_pkg::CMD_QUAD_IO && QUAD_LINES_ENABLE_BIT) begin
                d.kind  = mfr_pkg::K_QUAD_IO;
                d.width = mfr_pkg::LANE_4;
              end else begin
                d.phase = mfr_pkg::PH_IGNORE;
              end
            end else if (sh_n[7:0] == mfr_pkg::CMD_DUAL_OUT) begin
              d.kind = mfr_pkg::K_DUAL_OUT;
            end else if (sh_n[7:0] == mfr_pkg::CMD_QUAD_OUT && QUAD_LINES_ENABLE_BIT) begin
              d.kind = mfr_pkg::K_QUAD_OUT;
            end else if (sh_n[7:0] == mfr_pkg::CMD_DUAL_IO) begin
              d.kind  = mfr_pkg::K_DUAL_IO;
              d.width = mfr_pkg::LANE_2;
            end else if (sh_n[7:0] == mfr_pkg::CMD_QUAD_IO && QUAD_LINES_ENABLE_BIT) begin
              d.kind  = mfr_pkg::K_QUAD_IO;
              d.width = mfr_pkg::LANE_4;
            end else begin
              d.phase = mfr_pkg::PH_IGNORE;
            end
          end
        end
        mfr_pkg::PH_ADDR: begin
          if (rise) begin
            d.sh  = sh_n;
            d.cnt = cnt_next;
          end
          if (addr_done) begin
            d.cnt      = 5'h00;
            d.faddr    = sh_n;
            d.fetch_on = 1'b1;
            d.wrap_act = (q.kind == mfr_pkg::K_QUAD_IO) && !QUAD_COMMAND_MODE &&
                         !q.wrap[mfr_pkg::WRAP_DISABLE_POS];
            if (q.kind == mfr_pkg::K_DUAL_IO || q.kind == mfr_pkg::K_QUAD_IO) begin
              d.phase = mfr_pkg::PH_MODE;
            end else begin
              d.phase = mfr_pkg::PH_DUMMY;
              d.dummy = mfr_pkg::DUMMY_OUT_READ;
            end
          end
        end
        mfr_pkg::PH_MODE: begin
          if (rise) begin
            d.sh  = sh_n;
            d.cnt = cnt_next;
          end
          if (mode_done) begin
            // Only the select pair matters; an all-ones exit pattern clears it.
            d.cont = (sh_n[mfr_pkg::CONT_SEL_HI:mfr_pkg::CONT_SEL_LO] ==
                      mfr_pkg::CONT_SEL_KEEP);
            d.cont_kind = q.kind;
            if (q.kind == mfr_pkg::K_DUAL_IO) begin
              d.dummy = mfr_pkg::DUMMY_DUAL_IO;
            end else if (QUAD_COMMAND_MODE) begin
              d.dummy = {1'b0, q.rdparam, 1'b0};
            end else begin
              d.dummy = mfr_pkg::DUMMY_QUAD_IO;
            end
            d.phase = (d.dummy == 4'h0) ? mfr_pkg::PH_DATA : mfr_pkg::PH_DUMMY;
          end
        end
        mfr_pkg::PH_DUMMY: begin
          // Line values during these clocks are never looked at.
          if (rise) begin
            d.dummy = q.dummy - 4'h1;
            if (q.dummy == 4'h1) begin
              d.phase = mfr_pkg::PH_DATA;
            end
          end
        end
        mfr_pkg::PH_DATA: begin
          if (fall) begin
            d.io_oe = lane_mask(dw);
            if (q.dleft == 4'h0) begin
              // An empty buffer means memory lagged; the fill byte shows it.
              out_byte = fifo_out_valid ? fifo_out_data : mfr_pkg::FILL_BYTE;
              pop      = fifo_out_valid;
              d.io_out = top_bits(out_byte, dw);
              d.dout   = shl(out_byte, dw);
              d.dleft  = mfr_pkg::BYTE_BITS - {1'b0, dw};
            end else begin
              d.io_out = top_bits(q.dout, dw);
              d.dout   = shl(q.dout, dw);
              d.dleft  = q.dleft - {1'b0, dw};
            end
          end
        end
        mfr_pkg::PH_IGNORE: begin
          d.phase = mfr_pkg::PH_IGNORE;
        end
        default: begin
          d.phase = mfr_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      q           <= '0;
      q.csn_sync  <= 3'h7;
      q.csn_lvl   <= 1'b1;
      q.phase     <= mfr_pkg::PH_IDLE;
      q.kind      <= mfr_pkg::K_NONE;
      q.cont_kind <= mfr_pkg::K_NONE;
      q.wrap      <= mfr_pkg::WRAP_RESET;
      q.rdparam   <= mfr_pkg::PARAM_RESET;
      q.cont      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  mfr_fifo #(
    .WIDTH (mfr_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (NRST),
    .flush     (q.flush),
    .in_valid  (accept && q.fetch_on),
    .in_ready  (fifo_in_ready),
    .in_data   (MEM_DATA),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  assign IO_OUT            = q.io_out;
  assign IO_OE             = q.io_oe;
  assign MEM_REQ           = q.req;
  assign MEM_ADDR          = q.faddr;
  assign CONT_MODE         = q.cont;
  assign WRAP_SETTING_BITS = q.wrap;
  assign READ_PARAM        = q.rdparam;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_data_fall;
    (q.phase == mfr_pkg::PH_DATA) && fall && !cs_end;
  endsequence

  sequence s_quad_mode_done;
    mode_done && (q.kind == mfr_pkg::K_QUAD_IO);
  endsequence

  chk_dual_lanes: assert property (s_data_fall ##0 (q.kind == mfr_pkg::K_DUAL_OUT)
    |=> (IO_OE == 4'h3)) else $error("dual read drives wrong lanes");
  chk_quad_lanes: assert property ((s_data_fall ##0 (q.kind == mfr_pkg::K_QUAD_OUT))
    |=> (IO_OE == 4'hf)) else $error("quad read drives wrong lanes");
  chk_quad_out_gate: assert property ((cmd_done && !QUAD_COMMAND_MODE &&
    sh_n[7:0] == mfr_pkg::CMD_QUAD_OUT && !QUAD_LINES_ENABLE_BIT)
    |=> (q.phase == mfr_pkg::PH_IGNORE) && (IO_OE == 4'h0)) else $error("quad output not gated");
  chk_quad_io_gate: assert property ((cmd_done && sh_n[7:0] == mfr_pkg::CMD_QUAD_IO &&
    !QUAD_LINES_ENABLE_BIT) |=> (q.phase == mfr_pkg::PH_IGNORE)) else $error("quad io not gated");
  chk_out_dummy: assert property ((addr_done && (q.kind == mfr_pkg::K_DUAL_OUT ||
    q.kind == mfr_pkg::K_QUAD_OUT)) |=> (q.phase == mfr_pkg::PH_DUMMY) && (q.dummy == 4'h8))
    else $error("output read dummy count wrong");
  chk_spi_dummy: assert property ((s_quad_mode_done ##0 !QUAD_COMMAND_MODE)
    |=> (q.phase == mfr_pkg::PH_DUMMY) && (q.dummy == 4'h4)) else $error("quad io dummy wrong");
  chk_qcm_default: assert property ((s_quad_mode_done ##0 QUAD_COMMAND_MODE &&
    q.rdparam == 2'h0) |=> (q.phase == mfr_pkg::PH_DATA)) else $error("data not after mode");
  chk_cont_keep: assert property ((mode_done && sh_n[5:4] == 2'h2)
    |=> CONT_MODE ##1 (!cs_start || q.cont) ) else $error("continuous mode not set");
  chk_cont_drop: assert property ((mode_done && sh_n[5:4] != 2'h2)
    |=> !CONT_MODE) else $error("continuous mode not cleared");
  chk_skip_code: assert property ((cs_start && q.cont)
    |=> (q.phase == mfr_pkg::PH_ADDR)) else $error("code byte not skipped");
  chk_param_reset: assert property ((RESET_INSTR && !PARAM_LOAD)
    |=> (READ_PARAM == 2'h0)) else $error("dummy select not reset");
  chk_wrap_turn: assert property ((accept && q.wrap_act &&
    ((q.faddr[7:0] & wmask) == wmask)) |=> ((MEM_ADDR[7:0] & wmask) == 8'h00) &&
    (MEM_ADDR[23:8] == $past(MEM_ADDR[23:8]))) else $error("wrap did not restart section");
  chk_addr_step: assert property ((accept && !q.wrap_act && !addr_done)
    |=> (MEM_ADDR == $past(MEM_ADDR) + 24'h000001)) else $error("address did not advance");

endmodule // mfr_front_end

// File: logic/mfr_pkg.sv
// Constants and types shared by the multi-line fast read front end.
package mfr_pkg;

  // Instruction codes accepted by the front end.
  localparam logic [7:0] CMD_DUAL_OUT = 8'h3b;
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6b;
  localparam logic [7:0] CMD_DUAL_IO  = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO  = 8'heb;

  // Bit counts of each phase on the serial lines.
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] MODE_BITS = 5'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int         ADDR_W    = 24;

  // Lane widths in bits per serial clock.
  localparam logic [2:0] LANE_1 = 3'h1;
  localparam logic [2:0] LANE_2 = 3'h2;
  localparam logic [2:0] LANE_4 = 3'h4;

  // Dummy clocks after the address or after the continuous-mode byte.
  localparam logic [3:0] DUMMY_OUT_READ = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_IO  = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_IO  = 4'h0;

  // Continuous-mode byte field that keeps the instruction code skipped.
  localparam int         CONT_SEL_HI  = 5;
  localparam int         CONT_SEL_LO  = 4;
  localparam logic [1:0] CONT_SEL_KEEP = 2'h2;

  // Wrap setting bits: bit 0 disables wrap, bits 2..1 select the length.
  localparam int         WRAP_DISABLE_POS = 0;
  localparam int         WRAP_LEN_HI      = 2;
  localparam int         WRAP_LEN_LO      = 1;
  localparam logic [2:0] WRAP_RESET       = 3'h1;
  localparam logic [7:0] WRAP_MASK_8      = 8'h07;
  localparam logic [7:0] WRAP_MASK_16     = 8'h0f;
  localparam logic [7:0] WRAP_MASK_32     = 8'h1f;
  localparam logic [7:0] WRAP_MASK_64     = 8'h3f;

  // Read parameter field reset value, which selects two dummy clocks.
  localparam logic [1:0] PARAM_RESET = 2'h0;

  // Byte shifted out when the prefetch buffer has run dry.
  localparam logic [7:0] FILL_BYTE  = 8'hff;
  localparam int         FIFO_DEPTH = 32;
  localparam int         FIFO_WIDTH = 8;

  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_IGNORE
  } mfr_phase_t;

  typedef enum logic [2:0] {
    K_NONE, K_DUAL_OUT, K_QUAD_OUT, K_DUAL_IO, K_QUAD_IO
  } mfr_kind_t;

endpackage
